// >>> inc/isr_defines.svh
// bit positions, reset values and error-code ranges of the status block
// assumes inclusion by bare name from the design; the package does not include it
`ifndef ISR_DEFINES_SVH
`define ISR_DEFINES_SVH
`define ISR_ALM_QNE 4
`define ISR_ALM_QOVF 5
`define ISR_ALM_TRIG0 6
`define ISR_ALM_TRIG4 9
`define ISR_ALM_LOWER 12
`define ISR_ALM_UPPER 13
`define ISR_ALM_EVT_MASK 16'h302f
`define ISR_ALM_RESET 16'h0000
`define ISR_ESR_OPC 0
`define ISR_ESR_QRY 2
`define ISR_ESR_DEV 3
`define ISR_ESR_EXE 4
`define ISR_ESR_CMD 5
`define ISR_ESR_PON 7
`define ISR_ESR_RESET 8'h80
`define ISR_STB_ALM 1
`define ISR_STB_ERR 2
`define ISR_STB_QUES 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
`define ISR_STB_OPER 7
`define ISR_STB_RESET 8'h00
`define ISR_CMD_HI (-100)
`define ISR_CMD_LO (-199)
`define ISR_EXE_HI (-200)
`define ISR_EXE_LO (-299)
`define ISR_DEV_HI (-300)
`define ISR_DEV_LO (-399)
`endif

// >>> inc/isr_pkg.sv
// types shared by the status-reporting block
// assumes nothing beyond a SystemVerilog compiler
package isr_pkg;
	typedef enum {cls_none, cls_cmd, cls_exe, cls_dev} isr_err_class_e;
endpackage

// >>> design/isr_status.sv
// status reporting: alarm word, standard event byte, summary byte, error queue
// assumes all event and level inputs come from logic on core_clk
`include "isr_defines.svh"

// Behaviour
// - alarm bit 9 follows the fourth alarm channel's triggered level
// - alarm bit 12 latches any lower-limit alarm event
// - alarm bit 13 latches any upper-limit alarm event
// - event bit 0 set when operation-complete command finishes
// - event bit 2 set on any of three query-error conditions
// - event bit 3 set on -300 range or positive error codes
// - event bit 4 set on -200 range error codes
// - event bit 5 set on -100 range error codes
// - event bit 7 set by power-on, held until read
// - summary bit 1 when enabled alarm bits are set
// - summary bit 2 while error queue nonempty; reads pop oldest entry
// - summary bit 3 when enabled questionable bits are set
// - summary bit 4 while output message is waiting
// - summary bit 5 when enabled standard event bits are set
// - summary bit 6 and service request from enabled summary bits
// - summary bit 7 when enabled operation bits are set
// - event-only alarm bits always read zero in the condition word
// - alarm bit 4 follows alarm queue not empty
module isr_status #(
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] alarm_event,
	input wire logic [3:0] alarm_trig,
	input wire logic alarm_q_not_empty,
	input wire logic alarm_q_overflow,
	input wire logic lower_limit_evt,
	input wire logic upper_limit_evt,
	input wire logic alarm_rd,
	input wire logic [15:0] alarm_en,
	output logic [15:0] alarm_data,
	output logic [15:0] alarm_cond,
	input wire logic opc_done,
	input wire logic qry_empty_read,
	input wire logic qry_interrupted,
	input wire logic qry_deadlock,
	input wire logic std_event_rd,
	input wire logic [7:0] ese_mask,
	output logic [7:0] std_event,
	input wire logic err_push,
	input wire logic [15:0] err_code,
	input wire logic error_queue_read_query,
	output logic [15:0] err_rd_data,
	output logic err_rd_valid,
	input wire logic [15:0] ques_data,
	input wire logic [15:0] questionable_enable_command,
	input wire logic [15:0] oper_data,
	input wire logic [15:0] operation_enable_command,
	input wire logic msg_avail,
	input wire logic [7:0] sre_mask,
	output logic [7:0] status_byte,
	output logic service_request
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [15:0] alarm;
		logic [15:0] cond;
		logic [7:0] esr;
		logic [7:0] stb;
		logic [DEPTH-1:0][15:0] q;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
		logic [15:0] err_out;
		logic err_valid;
	} isr_state_s;

	isr_state_s s;
	isr_state_s next_s;
	logic rst_meta;
	logic rst_sync;

	// release reset cleanly; assertion is still immediate
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// codes outside every band still queue but flag no event bit
	function automatic isr_pkg::isr_err_class_e classify(input logic [15:0] code);
		int v;
		v = int'($signed(code));
		if (v > 0)
			classify = isr_pkg::cls_dev;
		else if (v <= `ISR_DEV_HI && v >= `ISR_DEV_LO)
			classify = isr_pkg::cls_dev;
		else if (v <= `ISR_EXE_HI && v >= `ISR_EXE_LO)
			classify = isr_pkg::cls_exe;
		else if (v <= `ISR_CMD_HI && v >= `ISR_CMD_LO)
			classify = isr_pkg::cls_cmd;
		else
			classify = isr_pkg::cls_none;
	endfunction

	// explicit wrap, so the depth need not be a power of two
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	isr_pkg::isr_err_class_e push_cls;
	logic [15:0] alm_set;
	logic [15:0] alm_lvl;
	logic [7:0] esr_set;
	logic [7:0] sum;
	logic q_full;
	logic do_push;
	logic do_pop;

	always_comb
	begin
		next_s = s;
		push_cls = err_push ? classify(err_code) : isr_pkg::cls_none;

		// event bits latch; a new event in the read cycle survives the clear
		alm_set = '0;
		alm_set[3:0] = alarm_event;
		alm_set[`ISR_ALM_QOVF] = alarm_q_overflow;
		alm_set[`ISR_ALM_LOWER] = lower_limit_evt;
		alm_set[`ISR_ALM_UPPER] = upper_limit_evt;
		alm_lvl = '0;
		alm_lvl[`ISR_ALM_QNE] = alarm_q_not_empty;
		alm_lvl[`ISR_ALM_TRIG4:`ISR_ALM_TRIG0] = alarm_trig;
		next_s.alarm = (((alarm_rd ? 16'h0000 : s.alarm) | alm_set) & `ISR_ALM_EVT_MASK)
			| alm_lvl;
		next_s.cond = alm_lvl;

		esr_set = '0;
		esr_set[`ISR_ESR_OPC] = opc_done;
		esr_set[`ISR_ESR_QRY] = qry_empty_read | qry_interrupted | qry_deadlock;
		esr_set[`ISR_ESR_DEV] = (push_cls == isr_pkg::cls_dev);
		esr_set[`ISR_ESR_EXE] = (push_cls == isr_pkg::cls_exe);
		esr_set[`ISR_ESR_CMD] = (push_cls == isr_pkg::cls_cmd);
		// power-on bit only comes from the reset value
		next_s.esr = (std_event_rd ? 8'h00 : s.esr) | esr_set;

		// queue full drops the newest entry; the oldest are kept
		q_full = (s.cnt == CW'(DEPTH));
		do_pop = error_queue_read_query && (s.cnt != '0);
		do_push = err_push && (!q_full || do_pop);
		next_s.err_valid = error_queue_read_query;
		if (error_queue_read_query)
			next_s.err_out = do_pop ? s.q[s.rd] : 16'h0000;
		if (do_pop)
			next_s.rd = bump(s.rd);
		if (do_push)
		begin
			next_s.q[s.wr] = err_code;
			next_s.wr = bump(s.wr);
		end
		if (do_push && !do_pop)
			next_s.cnt = s.cnt + CW'(1);
		else if (do_pop && !do_push)
			next_s.cnt = s.cnt - CW'(1);

		sum = '0;
		sum[`ISR_STB_ALM] = |(s.alarm & alarm_en);
		sum[`ISR_STB_ERR] = (s.cnt != '0);
		sum[`ISR_STB_QUES] = |(ques_data & questionable_enable_command);
		sum[`ISR_STB_MAV] = msg_avail;
		sum[`ISR_STB_ESB] = |(s.esr & ese_mask);
		sum[`ISR_STB_OPER] = |(oper_data & operation_enable_command);
		// request bit itself is masked out so it cannot hold itself on
		sum[`ISR_STB_RQS] = |(sum & sre_mask & 8'hbf);
		next_s.stb = sum;
	end

	always_ff @(posedge core_clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			s <= '0;
			s.alarm <= `ISR_ALM_RESET;
			s.esr <= `ISR_ESR_RESET;
			s.stb <= `ISR_STB_RESET;
		end
		else
			s <= next_s;
	end

	assign alarm_data = s.alarm;
	assign alarm_cond = s.cond;
	assign std_event = s.esr;
	assign status_byte = s.stb;
	assign service_request = s.stb[`ISR_STB_RQS];
	assign err_rd_data = s.err_out;
	assign err_rd_valid = s.err_valid;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync);

	alarm_trig_four_a: assert property (alarm_trig[3] |=> alarm_data[9])
		else $error("alarm bit 9 missed trigger");
	lower_limit_a: assert property (lower_limit_evt |=> alarm_data[12] [*2] or
		(alarm_data[12] ##1 1'b1))
		else $error("lower limit event lost");
	upper_limit_a: assert property (upper_limit_evt |=> alarm_data[13])
		else $error("upper limit event lost");
	opc_event_a: assert property (opc_done |=> std_event[0])
		else $error("operation complete not latched");
	query_error_a: assert property ((qry_empty_read || qry_interrupted || qry_deadlock)
		|=> std_event[2])
		else $error("query error not latched");
	device_error_a: assert property ((err_push && int'($signed(err_code)) > 0)
		|=> std_event[3])
		else $error("device error not latched");
	exec_error_a: assert property ((err_push && err_code == 16'hff38) |=> std_event[4]
		&& std_event[5] == $past(std_event[5] && !std_event_rd))
		else $error("execution error misclassified");
	cmd_error_a: assert property ((err_push && err_code == 16'hff9c) |=> std_event[5]
		&& std_event[4] == $past(std_event[4] && !std_event_rd))
		else $error("command error misclassified");
	esr_read_clear_a: assert property ((std_event_rd && !opc_done && !err_push
		&& !qry_empty_read && !qry_interrupted && !qry_deadlock)
		|=> std_event == 8'h00)
		else $error("event byte not cleared by read");
	power_on_hold_a: assert property ((std_event[7] && !std_event_rd) |=> std_event[7])
		else $error("power-on bit dropped early");
	// summary checks wait one edge after reset leaves, so $past sees live state
	alarm_summary_a: assert property ($past(rst_sync) |->
		status_byte[1] == $past(|(alarm_data & alarm_en)))
		else $error("alarm summary wrong");
	err_queue_a: assert property ((err_push && status_byte[2] == 1'b0 && s.cnt == '0
		&& !error_queue_read_query) |=> ##1 status_byte[2])
		else $error("error queue summary missing");
	ques_summary_a: assert property ($past(rst_sync) |-> status_byte[3] ==
		$past(|(ques_data & questionable_enable_command)))
		else $error("questionable summary wrong");
	msg_summary_a: assert property ($past(rst_sync) |->
		status_byte[4] == $past(msg_avail))
		else $error("message summary wrong");
	esb_summary_a: assert property ($past(rst_sync) |->
		status_byte[5] == $past(|(std_event & ese_mask)))
		else $error("event summary wrong");
	srq_link_a: assert property ($past(rst_sync) |-> service_request == status_byte[6]
		&& status_byte[6] == |(status_byte & $past(sre_mask) & 8'hbf))
		else $error("service request wrong");
	oper_summary_a: assert property ($past(rst_sync) |-> status_byte[7] ==
		$past(|(oper_data & operation_enable_command)))
		else $error("operation summary wrong");
	cond_zero_a: assert property (alarm_cond[3:0] == 4'h0 && alarm_cond[5] == 1'b0
		&& alarm_cond[13:12] == 2'b00)
		else $error("event-only bit in condition word");
	alarm_queue_a: assert property (alarm_q_not_empty |=> alarm_data[4])
		else $error("alarm queue bit missing");
	reserved_zero_a: assert property (alarm_data[11:10] == 2'b00 && alarm_data[15:14] == 2'b00
		&& std_event[1] == 1'b0 && std_event[6] == 1'b0 && status_byte[0] == 1'b0)
		else $error("reserved bit set");

	// one latch check per alarm channel
	for (genvar g = 0; g < 4; g++)
	begin : gen_alarm_evt
		alarm_event_a: assert property (alarm_event[g] |=> alarm_data[g])
			else $error("alarm event not latched");
	end

	// set wins: an event in the read cycle must survive the clear
	esr_set_wins_a: assert property ((std_event_rd && opc_done) |=> std_event[0])
		else $error("event lost in read cycle");
	alarm_set_wins_a: assert property ((alarm_rd && upper_limit_evt) |=> alarm_data[13])
		else $error("alarm event lost in read cycle");
	alarm_clear_a: assert property ((alarm_rd && alarm_event == 4'h0
		&& !alarm_q_overflow && !lower_limit_evt && !upper_limit_evt)
		|=> (alarm_data & `ISR_ALM_EVT_MASK) == 16'h0000)
		else $error("alarm event bits not cleared by read");
	qovf_latch_a: assert property (alarm_q_overflow |=> alarm_data[5])
		else $error("queue overflow not latched");
	trig_level_a: assert property ($past(rst_sync) |-> alarm_data[9:6] == $past(alarm_trig))
		else $error("triggered levels wrong");
	cond_level_a: assert property ($past(rst_sync) |-> alarm_cond[9:6] == $past(alarm_trig)
		&& alarm_cond[4] == $past(alarm_q_not_empty))
		else $error("condition word levels wrong");
	qne_low_a: assert property (!alarm_q_not_empty |=> !alarm_data[4])
		else $error("alarm queue bit stuck");
	empty_read_a: assert property (qry_empty_read |=> std_event[2])
		else $error("empty read not flagged");
	interrupted_a: assert property (qry_interrupted |=> std_event[2])
		else $error("interrupted query not flagged");
	deadlock_a: assert property (qry_deadlock |=> std_event[2])
		else $error("buffer deadlock not flagged");
	dev_range_a: assert property ((err_push && err_code == 16'hfed4) |=> std_event[3])
		else $error("device range code not flagged");
	power_on_clear_a: assert property (std_event_rd |=> !std_event[7])
		else $error("power-on bit kept after read");
	pon_no_set_a: assert property (!std_event[7] |=> !std_event[7])
		else $error("power-on bit set outside reset");
	pop_valid_a: assert property (err_rd_valid == $past(error_queue_read_query))
		else $error("error read valid wrong");
	empty_pop_a: assert property ((error_queue_read_query && s.cnt == '0)
		|=> err_rd_data == 16'h0000)
		else $error("empty pop returned data");
	err_drain_a: assert property ((error_queue_read_query && !err_push && s.cnt == CW'(1))
		|=> ##1 !status_byte[2])
		else $error("error summary stuck after drain");
	// count checks guard the full and empty ends of the queue
	queue_bound_a: assert property (s.cnt <= CW'(DEPTH))
		else $error("error count beyond depth");
	full_drop_a: assert property ((err_push && q_full && !error_queue_read_query)
		|=> s.cnt == CW'(DEPTH))
		else $error("push while full changed the count");
	pop_count_a: assert property ((error_queue_read_query && !err_push && s.cnt != '0)
		|=> s.cnt == $past(s.cnt) - CW'(1))
		else $error("pop did not shrink the queue");
	push_count_a: assert property ((err_push && !error_queue_read_query && !q_full)
		|=> s.cnt == $past(s.cnt) + CW'(1))
		else $error("push did not grow the queue");

	srq_raise_c: cover property (!service_request ##1 service_request);
	queue_fill_c: cover property (s.cnt == CW'(DEPTH));
	read_pop_c: cover property (error_queue_read_query && s.cnt != '0 ##1 err_rd_valid);
	clear_race_c: cover property (std_event_rd && opc_done);
	full_drop_c: cover property (err_push && q_full && !error_queue_read_query);
endmodule

// >>> testbench/isr_host.sv
// host model: reads the event byte and pops the error queue
// assumes the status block samples requests on rising core_clk
module isr_host (
	input wire logic core_clk,
	input wire logic [7:0] std_event,
	input wire logic [15:0] err_rd_data,
	input wire logic err_rd_valid,
	output logic std_event_rd,
	output logic error_queue_read_query
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		std_event_rd = 1'b0;
		error_queue_read_query = 1'b0;
	end
	// data is taken at the edge that accepts the read, before it clears
	task automatic read_esr(output logic [7:0] v);
		@(posedge core_clk);
		std_event_rd <= 1'b1;
		@(posedge core_clk);
		v = std_event;
		std_event_rd <= 1'b0;
	endtask
	task automatic pop_err(output logic [15:0] d, output logic vld);
		@(posedge core_clk);
		error_queue_read_query <= 1'b1;
		@(posedge core_clk);
		error_queue_read_query <= 1'b0;
		#1;
		d = err_rd_data;
		vld = err_rd_valid;
	endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the status-reporting block
// assumes isr_status and the host model isr_host are compiled first
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [3:0] sel; logic [15:0] code; logic [15:0] alm; logic [7:0] esr;
		logic [7:0] sb;} isr_row_s;
	logic core_clk, rst_n, alarm_rd, lower_limit_evt, upper_limit_evt, alarm_q_not_empty;
	logic opc_done, qry_empty_read, qry_interrupted, qry_deadlock, err_push, msg_avail;
	logic alarm_q_overflow;
	logic err_rd_valid, service_request, std_event_rd, error_queue_read_query, vld;
	logic [3:0] alarm_event, alarm_trig;
	logic [15:0] alarm_data, alarm_cond, err_code, err_rd_data, ques_data, oper_data, d;
	logic [15:0] alarm_en, questionable_enable_command, operation_enable_command;
	logic [7:0] std_event, status_byte, ese_mask, sre_mask, v;
	int n_errors, compares;
	// masks all open; the queue bit stays up from the first push on
	isr_row_s rows [13] = '{'{4'h0, 16'h0, 16'h0, 8'h01, 8'h60}, '{4'h1, 16'h0, 16'h0, 8'h04, 8'h60},
		'{4'h2, 16'h0, 16'h0, 8'h04, 8'h60}, '{4'h3, 16'h0, 16'h0, 8'h04, 8'h60},
		'{4'h4, 16'hff9c, 16'h0, 8'h20, 8'h64}, '{4'h4, 16'hff38, 16'h0, 8'h10, 8'h64},
		'{4'h4, 16'hfed4, 16'h0, 8'h08, 8'h64}, '{4'h4, 16'h0005, 16'h0, 8'h08, 8'h64},
		'{4'h4, 16'hfc18, 16'h0, 8'h00, 8'h44}, '{4'h5, 16'h0, 16'h1000, 8'h00, 8'h46},
		'{4'h6, 16'h0, 16'h2000, 8'h00, 8'h46}, '{4'h7, 16'h0, 16'h0200, 8'h00, 8'h46},
		'{4'h8, 16'h0, 16'h0010, 8'h00, 8'h46}};
	logic [15:0] pops [5] = '{16'hff9c, 16'hff38, 16'hfed4, 16'h0005, 16'h0000};
	isr_status dut (.core_clk, .rst_n, .alarm_event, .alarm_trig, .alarm_q_not_empty,
		.alarm_q_overflow, .lower_limit_evt, .upper_limit_evt, .alarm_rd, .alarm_en,
		.alarm_data, .alarm_cond, .opc_done, .qry_empty_read, .qry_interrupted, .qry_deadlock,
		.std_event_rd, .ese_mask, .std_event, .err_push, .err_code, .error_queue_read_query,
		.err_rd_data, .err_rd_valid, .ques_data, .questionable_enable_command, .oper_data,
		.operation_enable_command, .msg_avail, .sre_mask, .status_byte, .service_request);
	isr_host host (.core_clk, .std_event, .err_rd_data, .err_rd_valid, .std_event_rd,
		.error_queue_read_query);
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apply(isr_row_s r, logic on);
		case (r.sel)
			4'h0: opc_done <= on;
			4'h1: qry_empty_read <= on;
			4'h2: qry_interrupted <= on;
			4'h3: qry_deadlock <= on;
			4'h4:
			begin
				err_push <= on;
				err_code <= r.code;
			end
			4'h5: lower_limit_evt <= on;
			4'h6: upper_limit_evt <= on;
			4'h7: alarm_trig[3] <= on;
			default: alarm_q_not_empty <= on;
		endcase
	endtask
	task automatic end_of_test;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial
	begin
		#(40 * 4000);
		n_errors++;
		end_of_test();
	end
	initial
	begin
		{rst_n, alarm_rd, lower_limit_evt, upper_limit_evt, alarm_q_not_empty, opc_done} = '0;
		{qry_empty_read, qry_interrupted, qry_deadlock, err_push, msg_avail, alarm_q_overflow} = '0;
		{alarm_event, alarm_trig, err_code, ques_data, oper_data} = '0;
		{alarm_en, questionable_enable_command, operation_enable_command} = '1;
		{ese_mask, sre_mask} = '1;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk("std_event", 16'h0080, {8'h00, std_event});
		host.read_esr(v);
		#1;
		chk("read std_event", 16'h0080, {8'h00, v});
		chk("std_event", 16'h0000, {8'h00, std_event});
		$display("test reset done");
		foreach (rows[i])
		begin
			@(posedge core_clk);
			apply(rows[i], 1'b1);
			@(posedge core_clk);
			if (rows[i].sel < 4'h7)
				apply(rows[i], 1'b0);
			@(posedge core_clk);
			#1;
			chk("alarm_data", rows[i].alm, alarm_data);
			chk("alarm_cond", rows[i].alm & 16'h03d0, alarm_cond);
			chk("std_event", {8'h00, rows[i].esr}, {8'h00, std_event});
			chk("status_byte", {8'h00, rows[i].sb}, {8'h00, status_byte});
			chk("service_request", {15'h0000, rows[i].sb[6]}, {15'h0000, service_request});
			apply(rows[i], 1'b0);
			alarm_rd <= 1'b1;
			host.read_esr(v);
			chk("read std_event", {8'h00, rows[i].esr}, {8'h00, v});
			alarm_rd <= 1'b0;
			repeat (2) @(posedge core_clk);
			$display("test row %0d done", i);
		end
		// direct summary sources reach the byte one edge later
		msg_avail <= 1'b1;
		ques_data <= 16'h0001;
		oper_data <= 16'h8000;
		repeat (2) @(posedge core_clk);
		#1;
		chk("status_byte", 16'h00dc, {8'h00, status_byte});
		msg_avail <= 1'b0;
		ques_data <= 16'h0000;
		oper_data <= 16'h0000;
		$display("test direct sources done");
		for (int k = 0; k < 5; k++)
		begin
			host.pop_err(d, vld);
			chk("err_rd_data", pops[k], d);
			if (k < 4)
				chk("err_rd_valid", 16'h0001, {15'h0000, vld});
		end
		repeat (2) @(posedge core_clk);
		#1;
		chk("status_byte", 16'h0000, {8'h00, status_byte});
		$display("test error queue done");
		// events that meet the clearing read in the same cycle must survive it
		fork
			host.read_esr(v);
			begin
				@(posedge core_clk);
				{opc_done, alarm_rd, alarm_q_overflow} <= 3'b111;
				alarm_event <= 4'h1;
				@(posedge core_clk);
				{opc_done, alarm_rd, alarm_q_overflow} <= 3'b000;
				alarm_event <= 4'h0;
			end
		join
		#1;
		chk("read std_event", 16'h0000, {8'h00, v});
		chk("std_event", 16'h0001, {8'h00, std_event});
		chk("alarm_data", 16'h0021, alarm_data);
		chk("alarm_cond", 16'h0000, alarm_cond);
		$display("test read race done");
		// reset in mid-run brings back the power-on bit
		rst_n <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("std_event", 16'h0080, {8'h00, std_event});
		chk("alarm_data", 16'h0000, alarm_data);
		chk("status_byte", 16'h0000, {8'h00, status_byte});
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk("status_byte", 16'h0060, {8'h00, status_byte});
		chk("service_request", 16'h0001, {15'h0000, service_request});
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
